// *** design/trg_defines.svh ***
// trg_defines.svh: offsets, field positions, reset values and timing of the trigger timing and pattern block
// assumes a 50 MHz core clock and a 32-bit AXI4-Lite register bus
`ifndef TRG_DEFINES_SVH
`define TRG_DEFINES_SVH

`define TRG_OFS_CTRL 8'h00
`define TRG_OFS_HDELAY 8'h04
`define TRG_OFS_FDELAY 8'h08
`define TRG_OFS_GATEW 8'h0C
`define TRG_OFS_CDELAY 8'h10
`define TRG_OFS_SDELAY 8'h14
`define TRG_OFS_SEQTEST 8'h18
`define TRG_OFS_STATUS 8'h1C
`define TRG_OFS_TEST_LEFT 8'h20
`define TRG_OFS_TEST_RIGHT 8'h24
`define TRG_OFS_TEST_OUT 8'h28
`define TRG_OFS_TBL_DATA 8'h2C
`define TRG_OFS_TBL_CMD 8'h30
`define TRG_OFS_TBL_READ 8'h34

`define TRG_CTRL_MODE_LSB 0
`define TRG_CTRL_ONE_EVENT 4
`define TRG_CTRL_SEQ_TEST 5
`define TRG_CTRL_REARM 6
`define TRG_CTRL_RESET 7'h00
`define TRG_DELAY_RESET 8'h00
`define TRG_CDELAY_RESET 5'h01

`define TRG_W_FIRST_LSB 0
`define TRG_W_SECOND_LSB 5
`define TRG_W_NO_HIT 10
`define TRG_W_TOO_MANY 11
`define TRG_W_FIRST_VALID 12
`define TRG_W_SECOND_VALID 13

`define TRG_CLK_PERIOD_PS 20000
`define TRG_CLK_PERIOD_NS 20
`define TRG_CAP_BASE_PS 12500
`define TRG_CAP_STEP_PS 500
`define TRG_CLS_STEP_PS 6000
`define TRG_STB_BASE_PS 30000
`define TRG_STB_STEP_PS 1000
`define TRG_STB_WIDTH_PS 20000
`define TRG_WDOG_NS 10000000
`define TRG_WDOG_CYCLES (`TRG_WDOG_NS / `TRG_CLK_PERIOD_NS)

`define TRG_RESP_OKAY 2'h0
`define TRG_RESP_SLVERR 2'h2

`endif

// *** design/trg_pkg.sv ***
// trg_pkg: types of the trigger timing and pattern block
// assumes trg_defines.svh holds every number except the state and mode encodings below
package trg_pkg;
	typedef enum logic [5:0] {
		SQ_IDLE = 6'h01,
		SQ_RUN = 6'h02,
		SQ_CLS = 6'h04,
		SQ_STB = 6'h08,
		SQ_PULSE = 6'h10,
		SQ_HALT = 6'h20
	} trg_seq_t;
	typedef enum logic [2:0] {
		MD_WORK = 3'h0,
		MD_OVERALL = 3'h1,
		MD_CLS_TEST = 3'h2,
		MD_READOUT = 3'h3,
		MD_LOAD = 3'h4
	} trg_mode_t;
endpackage : trg_pkg

// *** design/trg_lut.sv ***
// trg_lut: one 256k x 16 hit map table, synchronous write and registered read
// assumes address and data held stable by the caller during a write strobe
`timescale 1ns/1ns
module trg_lut (
	input wire logic clk_in,
	input wire logic write_n_in,
	input wire logic read_en_in,
	input wire logic [17:0] addr_in,
	input wire logic [15:0] data_in,
	output logic [15:0] data_out
);
	logic [15:0] mem [0:262143];

	always_ff @(posedge clk_in) begin
		if (!write_n_in) begin
			mem[addr_in] <= data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (read_en_in) begin
			data_out <= mem[addr_in];
		end else begin
			data_out <= 16'h0000;
		end
	end
endmodule : trg_lut

// *** design/trg_top.sv ***
// trg_top: trigger timing sequencer and hodoscope pattern unit with AXI4-Lite registers
// assumes START, VETO and hit lines are asynchronous pins; one 50 MHz clock
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ns
`include "trg_defines.svh"
module trg_top import trg_pkg::*; #(
	parameter int unsigned WDOG_CYCLES = `TRG_WDOG_CYCLES
) (
	input wire logic CORE_CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic [7:0] S_AXI_AWADDR_IN,
	input wire logic S_AXI_AWVALID_IN,
	output logic S_AXI_AWREADY_OUT,
	input wire logic [31:0] S_AXI_WDATA_IN,
	input wire logic [3:0] S_AXI_WSTRB_IN,
	input wire logic S_AXI_WVALID_IN,
	output logic S_AXI_WREADY_OUT,
	output logic [1:0] S_AXI_BRESP_OUT,
	output logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	input wire logic [7:0] S_AXI_ARADDR_IN,
	input wire logic S_AXI_ARVALID_IN,
	output logic S_AXI_ARREADY_OUT,
	output logic [31:0] S_AXI_RDATA_OUT,
	output logic [1:0] S_AXI_RRESP_OUT,
	output logic S_AXI_RVALID_OUT,
	input wire logic S_AXI_RREADY_IN,
	input wire logic START_IN,
	input wire logic VETO_IN,
	input wire logic [17:0] LEFT_HIT_LINES_IN,
	input wire logic [17:0] RIGHT_HIT_LINES_IN,
	output logic BUSY_OUT,
	output logic READY_OUT,
	output logic REARM_OUT,
	output logic SEQUENCER_ENABLE_OUT,
	output logic HIT_CAPTURE_CLOCK_OUT,
	output logic FIBRE_GATE_OUT,
	output logic CLASSIFIER_CLOCK_OUT,
	output logic RESULT_STROBE_OUT,
	output logic TEST_START_OUT,
	output logic TEST_CLASSIFIER_CLOCK_OUT,
	output logic INPUT_REG_ENABLE_N_OUT,
	output logic TABLE_ENABLE_N_OUT,
	output logic CLASSIFIER_DRIVER_ENABLE_N_OUT,
	output logic LEFT_TABLE_WRITE_N_OUT,
	output logic RIGHT_TABLE_WRITE_N_OUT,
	output logic [4:0] CARD1_LEFT_POS_OUT,
	output logic [4:0] CARD1_RIGHT_POS_OUT,
	output logic [4:0] CARD2_LEFT_POS_OUT,
	output logic [4:0] CARD2_RIGHT_POS_OUT,
	output logic [4:0] CARD3_RIGHT_POS_OUT,
	output logic [4:0] CARD4_LEFT_POS_OUT,
	output logic [4:0] CARD4_RIGHT_POS_OUT,
	output logic LEFT_NO_HIT_OUT,
	output logic RIGHT_NO_HIT_OUT,
	output logic LEFT_TOO_MANY_OUT,
	output logic RIGHT_TOO_MANY_OUT,
	output logic LEFT_FIRST_VALID_OUT,
	output logic LEFT_SECOND_VALID_OUT,
	output logic RIGHT_FIRST_VALID_OUT,
	output logic RIGHT_SECOND_VALID_OUT
);
	// nearest whole clock count, never below one
	function automatic logic [7:0] to_cycles(input int unsigned ps);
		int unsigned c;
		c = (ps + `TRG_CLK_PERIOD_PS / 2) / `TRG_CLK_PERIOD_PS;
		if (c < 1) begin
			c = 1;
		end
		return c[7:0];
	endfunction : to_cycles

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] result_strobe);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (result_strobe[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction : merge

	logic [6:0] ctrl_reg;
	logic [7:0] hdly_reg;
	logic [7:0] fdly_reg;
	logic [7:0] gatew_reg;
	logic [4:0] cdly_reg;
	logic [7:0] sdly_reg;
	logic [1:0] seqtest_reg;
	logic [1:0][17:0] tmap_reg;
	logic [31:0] tout_reg;
	logic [15:0] tdata_reg;
	logic [1:0] tbl_we_reg;
	logic [7:0] awaddr_reg;
	logic aw_full_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic w_full_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [1:0] rresp_reg;
	logic [31:0] rdata_reg;
	logic start_s1_reg, start_s2_reg, veto_s1_reg, veto_s2_reg;
	logic start_prev_reg, rearm_prev_reg;
	trg_seq_t state_reg;
	logic [7:0] hcnt_reg, fcnt_reg, gcnt_reg, ccnt_reg, scnt_reg, pcnt_reg;
	logic hdone_reg, fdone_reg, cap_reg, gate_reg, cls_reg, strobe_reg;
	logic [31:0] wdog_cnt_reg;
	logic wdog_pulse_reg;
	logic [1:0][17:0] hit_s1_reg, hit_s2_reg, map_reg;
	logic [1:0][15:0] tbl_rd;
	logic [1:0][15:0] drive_reg;

	trg_mode_t mode;
	logic m_work, m_overall, m_cls, m_readout, m_load;
	logic in_en, tbl_en, drv_en;
	logic busy, seq_test, start_src, start_edge, rearm_fall, wdog_trip, do_write;
	logic [7:0] hcyc, fcyc, gcyc, ccyc, scyc, pcyc;
	logic [31:0] status;

	assign mode = trg_mode_t'(ctrl_reg[`TRG_CTRL_MODE_LSB +: 3]);
	assign m_work = (mode == MD_WORK);
	assign m_overall = (mode == MD_OVERALL);
	assign m_cls = (mode == MD_CLS_TEST);
	assign m_readout = (mode == MD_READOUT);
	assign m_load = (mode == MD_LOAD);
	assign in_en = m_work;
	assign tbl_en = m_work | m_overall | m_readout;
	assign drv_en = m_work | m_overall | m_cls;
	assign INPUT_REG_ENABLE_N_OUT = !in_en;
	assign TABLE_ENABLE_N_OUT = !tbl_en;
	assign CLASSIFIER_DRIVER_ENABLE_N_OUT = !drv_en;
	assign LEFT_TABLE_WRITE_N_OUT = !tbl_we_reg[0];
	assign RIGHT_TABLE_WRITE_N_OUT = !tbl_we_reg[1];

	// delay codes to clock counts
	assign hcyc = to_cycles(`TRG_CAP_BASE_PS + `TRG_CAP_STEP_PS * 32'(hdly_reg));
	assign fcyc = to_cycles(`TRG_CAP_BASE_PS + `TRG_CAP_STEP_PS * 32'(fdly_reg));
	assign gcyc = to_cycles(`TRG_CAP_BASE_PS + `TRG_CAP_STEP_PS * 32'(gatew_reg));
	assign ccyc = to_cycles(`TRG_CLS_STEP_PS * ((cdly_reg == 5'h00) ? 32'd1 : 32'(cdly_reg)));
	assign scyc = to_cycles(`TRG_STB_BASE_PS + `TRG_STB_STEP_PS * 32'(sdly_reg));
	assign pcyc = to_cycles(`TRG_STB_WIDTH_PS);

	// AXI4-Lite write channel
	assign S_AXI_AWREADY_OUT = !aw_full_reg && !bvalid_reg;
	assign S_AXI_WREADY_OUT = !w_full_reg && !bvalid_reg;
	assign S_AXI_BVALID_OUT = bvalid_reg;
	assign S_AXI_BRESP_OUT = bresp_reg;
	assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;

	always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `TRG_RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
				aw_full_reg <= 1'b1;
				awaddr_reg <= S_AXI_AWADDR_IN;
			end
			if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
				w_full_reg <= 1'b1;
				wdata_reg <= S_AXI_WDATA_IN;
				wstrb_reg <= S_AXI_WSTRB_IN;
			end
			if (do_write) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= (awaddr_reg[1:0] != 2'h0 || awaddr_reg > `TRG_OFS_TBL_READ
					|| awaddr_reg == `TRG_OFS_STATUS || awaddr_reg == `TRG_OFS_TBL_READ)
					? `TRG_RESP_SLVERR : `TRG_RESP_OKAY;
			end else if (bvalid_reg && S_AXI_BREADY_IN) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// register file
	always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			ctrl_reg <= `TRG_CTRL_RESET;
			hdly_reg <= `TRG_DELAY_RESET;
			fdly_reg <= `TRG_DELAY_RESET;
			gatew_reg <= `TRG_DELAY_RESET;
			cdly_reg <= `TRG_CDELAY_RESET;
			sdly_reg <= `TRG_DELAY_RESET;
			seqtest_reg <= 2'h0;
			tmap_reg <= '0;
			tout_reg <= 32'h0000_0000;
			tdata_reg <= 16'h0000;
			tbl_we_reg <= 2'h0;
		end else begin
			tbl_we_reg <= 2'h0;
			if (do_write) begin
				unique case (awaddr_reg)
					`TRG_OFS_CTRL: ctrl_reg <= 7'(merge(32'(ctrl_reg), wdata_reg, wstrb_reg));
					`TRG_OFS_HDELAY: hdly_reg <= 8'(merge(32'(hdly_reg), wdata_reg, wstrb_reg));
					`TRG_OFS_FDELAY: fdly_reg <= 8'(merge(32'(fdly_reg), wdata_reg, wstrb_reg));
					`TRG_OFS_GATEW: gatew_reg <= 8'(merge(32'(gatew_reg), wdata_reg, wstrb_reg));
					`TRG_OFS_CDELAY: cdly_reg <= 5'(merge(32'(cdly_reg), wdata_reg, wstrb_reg));
					`TRG_OFS_SDELAY: sdly_reg <= 8'(merge(32'(sdly_reg), wdata_reg, wstrb_reg));
					`TRG_OFS_SEQTEST: seqtest_reg <= 2'(merge(32'(seqtest_reg), wdata_reg, wstrb_reg));
					`TRG_OFS_TEST_LEFT: tmap_reg[0] <= 18'(merge(32'(tmap_reg[0]), wdata_reg, wstrb_reg));
					`TRG_OFS_TEST_RIGHT: tmap_reg[1] <= 18'(merge(32'(tmap_reg[1]), wdata_reg, wstrb_reg));
					`TRG_OFS_TEST_OUT: tout_reg <= merge(tout_reg, wdata_reg, wstrb_reg);
					`TRG_OFS_TBL_DATA: tdata_reg <= 16'(merge(32'(tdata_reg), wdata_reg, wstrb_reg));
					// write strobe low for one cycle, only in load mode
					`TRG_OFS_TBL_CMD: tbl_we_reg <= (m_load && wstrb_reg[0]) ? wdata_reg[1:0] : 2'h0;
					default: ;
				endcase
			end
		end
	end

	// AXI4-Lite read channel
	assign status = {22'h000000, ctrl_reg[`TRG_CTRL_MODE_LSB +: 3], FIBRE_GATE_OUT, state_reg[5:0] == SQ_HALT,
		READY_OUT, BUSY_OUT, wdog_pulse_reg, 1'b0, seq_test};
	assign S_AXI_ARREADY_OUT = !rvalid_reg;
	assign S_AXI_RVALID_OUT = rvalid_reg;
	assign S_AXI_RDATA_OUT = rdata_reg;
	assign S_AXI_RRESP_OUT = rresp_reg;

	always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= `TRG_RESP_OKAY;
		end else if (S_AXI_ARVALID_IN && !rvalid_reg) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= `TRG_RESP_OKAY;
			unique case (S_AXI_ARADDR_IN)
				`TRG_OFS_CTRL: rdata_reg <= 32'(ctrl_reg);
				`TRG_OFS_HDELAY: rdata_reg <= 32'(hdly_reg);
				`TRG_OFS_FDELAY: rdata_reg <= 32'(fdly_reg);
				`TRG_OFS_GATEW: rdata_reg <= 32'(gatew_reg);
				`TRG_OFS_CDELAY: rdata_reg <= 32'(cdly_reg);
				`TRG_OFS_SDELAY: rdata_reg <= 32'(sdly_reg);
				`TRG_OFS_SEQTEST: rdata_reg <= 32'(seqtest_reg);
				`TRG_OFS_STATUS: rdata_reg <= status;
				`TRG_OFS_TEST_LEFT: rdata_reg <= 32'(tmap_reg[0]);
				`TRG_OFS_TEST_RIGHT: rdata_reg <= 32'(tmap_reg[1]);
				`TRG_OFS_TEST_OUT: rdata_reg <= tout_reg;
				`TRG_OFS_TBL_DATA: rdata_reg <= 32'(tdata_reg);
				`TRG_OFS_TBL_CMD: rdata_reg <= 32'h0000_0000;
				`TRG_OFS_TBL_READ: rdata_reg <= {tbl_rd[1], tbl_rd[0]};
				default: begin
					rdata_reg <= 32'h0000_0000;
					rresp_reg <= `TRG_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_reg && S_AXI_RREADY_IN) begin
			rvalid_reg <= 1'b0;
		end
	end

	// pin synchronisers and edge history
	always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			start_s1_reg <= 1'b0;
			start_s2_reg <= 1'b0;
			veto_s1_reg <= 1'b0;
			veto_s2_reg <= 1'b0;
			start_prev_reg <= 1'b0;
			rearm_prev_reg <= 1'b0;
		end else begin
			start_s1_reg <= START_IN;
			start_s2_reg <= start_s1_reg;
			veto_s1_reg <= VETO_IN;
			veto_s2_reg <= veto_s1_reg;
			start_prev_reg <= start_src;
			rearm_prev_reg <= ctrl_reg[`TRG_CTRL_REARM];
		end
	end

	assign seq_test = ctrl_reg[`TRG_CTRL_SEQ_TEST];
	assign SEQUENCER_ENABLE_OUT = !seq_test;
	assign TEST_START_OUT = seq_test & seqtest_reg[0];
	assign TEST_CLASSIFIER_CLOCK_OUT = seq_test & seqtest_reg[1];
	assign start_src = seq_test ? seqtest_reg[0] : start_s2_reg;
	assign start_edge = start_src && !start_prev_reg && !veto_s2_reg;
	assign rearm_fall = rearm_prev_reg && !ctrl_reg[`TRG_CTRL_REARM];
	assign busy = (state_reg == SQ_RUN) || (state_reg == SQ_CLS) || (state_reg == SQ_STB)
		|| (state_reg == SQ_PULSE);
	assign BUSY_OUT = busy;
	assign READY_OUT = (state_reg == SQ_HALT);
	assign wdog_trip = busy && (wdog_cnt_reg >= WDOG_CYCLES - 1);
	assign REARM_OUT = ctrl_reg[`TRG_CTRL_REARM] | wdog_pulse_reg;
	assign HIT_CAPTURE_CLOCK_OUT = cap_reg;
	assign FIBRE_GATE_OUT = gate_reg;
	assign CLASSIFIER_CLOCK_OUT = cls_reg;
	assign RESULT_STROBE_OUT = strobe_reg;

	// watchdog on busy
	always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			wdog_cnt_reg <= 32'h0000_0000;
			wdog_pulse_reg <= 1'b0;
		end else begin
			wdog_pulse_reg <= wdog_trip;
			wdog_cnt_reg <= (busy && !wdog_trip) ? wdog_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
		end
	end

	// sequencer
	always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			state_reg <= SQ_IDLE;
			{hcnt_reg, fcnt_reg, gcnt_reg, ccnt_reg, scnt_reg, pcnt_reg} <= '0;
			{hdone_reg, fdone_reg, cap_reg, gate_reg, cls_reg, strobe_reg} <= '0;
		end else begin
			cap_reg <= 1'b0;
			cls_reg <= 1'b0;
			if (wdog_trip) begin
				state_reg <= SQ_IDLE;
				gate_reg <= 1'b0;
				strobe_reg <= 1'b0;
			end else begin
				unique case (state_reg)
					SQ_IDLE: begin
						// later starts are only seen here, so busy ignores them
						if (start_edge) begin
							state_reg <= SQ_RUN;
							hcnt_reg <= hcyc;
							fcnt_reg <= fcyc;
							hdone_reg <= 1'b0;
							fdone_reg <= 1'b0;
						end
					end
					SQ_RUN: begin
						if (!hdone_reg) begin
							if (hcnt_reg == 8'h01) begin
								cap_reg <= 1'b1;
								hdone_reg <= 1'b1;
							end else begin
								hcnt_reg <= hcnt_reg - 8'h01;
							end
						end
						if (!fdone_reg && !gate_reg) begin
							if (fcnt_reg == 8'h01) begin
								gate_reg <= 1'b1;
								gcnt_reg <= gcyc;
							end else begin
								fcnt_reg <= fcnt_reg - 8'h01;
							end
						end else if (!fdone_reg) begin
							if (gcnt_reg == 8'h01) begin
								gate_reg <= 1'b0;
								fdone_reg <= 1'b1;
							end else begin
								gcnt_reg <= gcnt_reg - 8'h01;
							end
						end
						if (hdone_reg && fdone_reg) begin
							state_reg <= SQ_CLS;
							ccnt_reg <= ccyc;
						end
					end
					SQ_CLS: begin
						if (ccnt_reg == 8'h01) begin
							cls_reg <= 1'b1;
							state_reg <= SQ_STB;
							scnt_reg <= scyc;
						end else begin
							ccnt_reg <= ccnt_reg - 8'h01;
						end
					end
					SQ_STB: begin
						if (scnt_reg == 8'h01) begin
							strobe_reg <= 1'b1;
							state_reg <= SQ_PULSE;
							pcnt_reg <= pcyc;
						end else begin
							scnt_reg <= scnt_reg - 8'h01;
						end
					end
					SQ_PULSE: begin
						if (pcnt_reg == 8'h01) begin
							strobe_reg <= 1'b0;
							state_reg <= ctrl_reg[`TRG_CTRL_ONE_EVENT] ? SQ_HALT : SQ_IDLE;
						end else begin
							pcnt_reg <= pcnt_reg - 8'h01;
						end
					end
					SQ_HALT: begin
						if (rearm_fall) begin
							state_reg <= SQ_IDLE;
						end
					end
					default: state_reg <= SQ_IDLE;
				endcase
			end
		end
	end

	// per side: input register, table, output drive
	for (genvar s = 0; s < 2; s++) begin : g_side
		logic [17:0] addr;
		assign addr = in_en ? map_reg[s] : tmap_reg[s];

		always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
			if (SYS_RST_IN) begin
				hit_s1_reg[s] <= 18'h00000;
				hit_s2_reg[s] <= 18'h00000;
				map_reg[s] <= 18'h00000;
			end else begin
				hit_s1_reg[s] <= (s == 0) ? LEFT_HIT_LINES_IN : RIGHT_HIT_LINES_IN;
				hit_s2_reg[s] <= hit_s1_reg[s];
				if (cap_reg && in_en) begin
					map_reg[s] <= hit_s2_reg[s];
				end
			end
		end

		// table word holds positions and flags as loaded
		trg_lut u_lut (
			.clk_in(CORE_CLK_IN),
			.write_n_in(!tbl_we_reg[s]),
			.read_en_in(tbl_en),
			.addr_in(addr),
			.data_in(tdata_reg),
			.data_out(tbl_rd[s])
		);

		always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
			if (SYS_RST_IN) begin
				drive_reg[s] <= 16'h0000;
			end else if (m_cls) begin
				drive_reg[s] <= tout_reg[16*s +: 16];
			end else if (m_work || m_overall) begin
				drive_reg[s] <= tbl_rd[s];
			end else begin
				drive_reg[s] <= 16'h0000;
			end
		end
	end

	// card fan-out
	assign CARD1_LEFT_POS_OUT = drive_reg[0][`TRG_W_FIRST_LSB +: 5];
	assign CARD2_LEFT_POS_OUT = drive_reg[0][`TRG_W_FIRST_LSB +: 5];
	assign CARD4_LEFT_POS_OUT = drive_reg[0][`TRG_W_SECOND_LSB +: 5];
	assign CARD1_RIGHT_POS_OUT = drive_reg[1][`TRG_W_FIRST_LSB +: 5];
	assign CARD3_RIGHT_POS_OUT = drive_reg[1][`TRG_W_FIRST_LSB +: 5];
	assign CARD2_RIGHT_POS_OUT = drive_reg[1][`TRG_W_SECOND_LSB +: 5];
	assign CARD4_RIGHT_POS_OUT = drive_reg[1][`TRG_W_SECOND_LSB +: 5];
	assign LEFT_NO_HIT_OUT = drive_reg[0][`TRG_W_NO_HIT];
	assign RIGHT_NO_HIT_OUT = drive_reg[1][`TRG_W_NO_HIT];
	assign LEFT_TOO_MANY_OUT = drive_reg[0][`TRG_W_TOO_MANY];
	assign RIGHT_TOO_MANY_OUT = drive_reg[1][`TRG_W_TOO_MANY];
	assign LEFT_FIRST_VALID_OUT = drive_reg[0][`TRG_W_FIRST_VALID];
	assign LEFT_SECOND_VALID_OUT = drive_reg[0][`TRG_W_SECOND_VALID];
	assign RIGHT_FIRST_VALID_OUT = drive_reg[1][`TRG_W_FIRST_VALID];
	assign RIGHT_SECOND_VALID_OUT = drive_reg[1][`TRG_W_SECOND_VALID];
endmodule : trg_top

// *** verification/trg_top_monitor.sv ***
// trg_top_monitor: port-level assertions for trg_top
// assumes bind to trg_top, one clock, asynchronous active-high reset
`timescale 1ns/1ns
module trg_top_monitor #(
	parameter int unsigned WDOG_CYCLES = 500000
) (
	input wire logic CORE_CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic BUSY_OUT,
	input wire logic READY_OUT,
	input wire logic SEQUENCER_ENABLE_OUT,
	input wire logic CLASSIFIER_CLOCK_OUT,
	input wire logic RESULT_STROBE_OUT,
	input wire logic TEST_START_OUT,
	input wire logic TEST_CLASSIFIER_CLOCK_OUT,
	input wire logic INPUT_REG_ENABLE_N_OUT,
	input wire logic TABLE_ENABLE_N_OUT,
	input wire logic CLASSIFIER_DRIVER_ENABLE_N_OUT,
	input wire logic LEFT_TABLE_WRITE_N_OUT,
	input wire logic RIGHT_TABLE_WRITE_N_OUT
);
	int unsigned busy_cnt_reg;
	logic [2:0] en_n;
	logic [1:0] wr_n;
	assign en_n = {INPUT_REG_ENABLE_N_OUT, TABLE_ENABLE_N_OUT, CLASSIFIER_DRIVER_ENABLE_N_OUT};
	assign wr_n = {LEFT_TABLE_WRITE_N_OUT, RIGHT_TABLE_WRITE_N_OUT};
	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	// consecutive busy cycles
	always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) busy_cnt_reg <= 0;
		else busy_cnt_reg <= BUSY_OUT ? busy_cnt_reg + 1 : 0;
	end
	property p_stb; $rose(RESULT_STROBE_OUT) |=> !RESULT_STROBE_OUT; endproperty
	a_stb: assert property (p_stb) else $error("strobe too wide");
	property p_cls; CLASSIFIER_CLOCK_OUT |-> BUSY_OUT; endproperty
	a_cls: assert property (p_cls) else $error("classifier clock when idle");
	property p_tst; SEQUENCER_ENABLE_OUT |-> !TEST_START_OUT && !TEST_CLASSIFIER_CLOCK_OUT; endproperty
	a_tst: assert property (p_tst) else $error("test outputs not inhibited");
	property p_work; !INPUT_REG_ENABLE_N_OUT |-> en_n == 3'h0 && wr_n == 2'h3; endproperty
	a_work: assert property (p_work) else $error("work mode enables wrong");
	property p_load; wr_n != 2'h3 |-> en_n == 3'h7; endproperty
	a_load: assert property (p_load) else $error("table write outside load");
	property p_wpls; wr_n != 2'h3 |=> wr_n == 2'h3; endproperty
	a_wpls: assert property (p_wpls) else $error("table write not a pulse");
	property p_rdy; READY_OUT |-> !BUSY_OUT; endproperty
	a_rdy: assert property (p_rdy) else $error("ready while busy");
	property p_wdog; busy_cnt_reg <= WDOG_CYCLES + 2; endproperty
	a_wdog: assert property (p_wdog) else $error("busy outlived watchdog");
endmodule : trg_top_monitor

bind trg_top trg_top_monitor #(.WDOG_CYCLES(WDOG_CYCLES)) u_mon (.*);

// *** verification/trg_ctl_model.sv ***
// trg_ctl_model: trigger control stand-in driving start and hit lines
// assumes go_in is a one-cycle request from the bench
`timescale 1ns/1ns
module trg_ctl_model (
	input wire logic clk_in,
	input wire logic go_in,
	input wire logic dbl_in,
	input wire logic [17:0] left_in,
	input wire logic [17:0] right_in,
	output logic start_out,
	output logic [17:0] left_out,
	output logic [17:0] right_out
);
	int step_reg = 0;
	always @(posedge clk_in) begin
		if (go_in) step_reg <= 1;
		else if (step_reg != 0 && step_reg < 16) step_reg <= step_reg + 1;
		else step_reg <= 0;
	end
	// optional second edge lands while still busy
	assign start_out = step_reg inside {[1:3]} || (dbl_in && step_reg inside {[6:8]});
	// hits valid briefly, then a different map
	assign left_out = step_reg inside {[1:12]} ? left_in : ~left_in;
	assign right_out = step_reg inside {[1:12]} ? right_in : ~right_in;
endmodule : trg_ctl_model

// *** verification/trg_top_tb_top.sv ***
// trg_top_tb_top: self-checking bench for trg_top
// assumes trg_ctl_model drives start and hit lines
`timescale 1ns/1ns
`include "trg_defines.svh"
module trg_top_tb_top import trg_pkg::*;;
	logic CORE_CLK_IN = 0, SYS_RST_IN = 1, START_IN, VETO_IN = 0, go = 0, dbl = 0;
	logic [7:0] S_AXI_AWADDR_IN = 0, S_AXI_ARADDR_IN = 0;
	logic [31:0] S_AXI_WDATA_IN = 0, S_AXI_RDATA_OUT, rd;
	logic [3:0] S_AXI_WSTRB_IN = 4'hF;
	logic S_AXI_AWVALID_IN = 0, S_AXI_WVALID_IN = 0, S_AXI_BREADY_IN = 0, S_AXI_ARVALID_IN = 0, S_AXI_RREADY_IN = 0;
	logic S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT, S_AXI_BVALID_OUT, S_AXI_ARREADY_OUT, S_AXI_RVALID_OUT;
	logic [1:0] S_AXI_BRESP_OUT, S_AXI_RRESP_OUT, rs;
	logic [17:0] LEFT_HIT_LINES_IN, RIGHT_HIT_LINES_IN, lh = 18'h104, rh = 0;
	logic BUSY_OUT, READY_OUT, REARM_OUT, SEQUENCER_ENABLE_OUT, HIT_CAPTURE_CLOCK_OUT, FIBRE_GATE_OUT;
	logic CLASSIFIER_CLOCK_OUT, RESULT_STROBE_OUT, TEST_START_OUT, TEST_CLASSIFIER_CLOCK_OUT;
	logic INPUT_REG_ENABLE_N_OUT, TABLE_ENABLE_N_OUT, CLASSIFIER_DRIVER_ENABLE_N_OUT;
	logic LEFT_TABLE_WRITE_N_OUT, RIGHT_TABLE_WRITE_N_OUT, LEFT_NO_HIT_OUT, RIGHT_NO_HIT_OUT;
	logic LEFT_TOO_MANY_OUT, RIGHT_TOO_MANY_OUT, LEFT_FIRST_VALID_OUT, LEFT_SECOND_VALID_OUT;
	logic RIGHT_FIRST_VALID_OUT, RIGHT_SECOND_VALID_OUT;
	logic [4:0] CARD1_LEFT_POS_OUT, CARD1_RIGHT_POS_OUT, CARD2_LEFT_POS_OUT, CARD2_RIGHT_POS_OUT;
	logic [4:0] CARD3_RIGHT_POS_OUT, CARD4_LEFT_POS_OUT, CARD4_RIGHT_POS_OUT;
	int n_mismatch = 0, compares = 0, g, s, cap, stb, rr, bz;
	// rows: mode, then {input, table, driver} enables
	logic [2:0] men [5] = '{3'h0, 3'h4, 3'h6, 3'h5, 3'h7};
	trg_top #(.WDOG_CYCLES(30)) u_dut (.*);
	trg_ctl_model u_ctl (.clk_in(CORE_CLK_IN), .go_in(go), .dbl_in(dbl), .left_in(lh), .right_in(rh),
		.start_out(START_IN), .left_out(LEFT_HIT_LINES_IN), .right_out(RIGHT_HIT_LINES_IN));
	initial forever #10 CORE_CLK_IN = ~CORE_CLK_IN;
	task automatic conclude;
		if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge CORE_CLK_IN);
	endtask : tick
	task automatic bound(inout int n);
		n++;
		if (n > 50) begin
			chk(0, 1);
			conclude();
		end
	endtask : bound
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, b;
		int n;
		n = 0;
		S_AXI_AWADDR_IN <= a;
		S_AXI_WDATA_IN <= d;
		S_AXI_AWVALID_IN <= 1;
		S_AXI_WVALID_IN <= 1;
		S_AXI_BREADY_IN <= 1;
		do begin
			@(negedge CORE_CLK_IN);
			ta = S_AXI_AWREADY_OUT & S_AXI_AWVALID_IN;
			tw = S_AXI_WREADY_OUT & S_AXI_WVALID_IN;
			b = S_AXI_BVALID_OUT;
			rs = S_AXI_BRESP_OUT;
			@(posedge CORE_CLK_IN);
			if (ta) S_AXI_AWVALID_IN <= 0;
			if (tw) S_AXI_WVALID_IN <= 0;
			bound(n);
		end while (b !== 1'b1);
		S_AXI_BREADY_IN <= 0;
		tick(1);
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		logic ta, b;
		int n;
		n = 0;
		S_AXI_ARADDR_IN <= a;
		S_AXI_ARVALID_IN <= 1;
		S_AXI_RREADY_IN <= 1;
		do begin
			@(negedge CORE_CLK_IN);
			ta = S_AXI_ARREADY_OUT & S_AXI_ARVALID_IN;
			b = S_AXI_RVALID_OUT;
			rd = S_AXI_RDATA_OUT;
			rs = S_AXI_RRESP_OUT;
			@(posedge CORE_CLK_IN);
			if (ta) S_AXI_ARVALID_IN <= 0;
			bound(n);
		end while (b !== 1'b1);
		S_AXI_RREADY_IN <= 0;
		tick(1);
	endtask : rdr
	// one start request, then watch a fixed window
	task automatic fire(input logic d);
		go <= 1;
		dbl <= d;
		tick(1);
		go <= 0;
		{g, s, cap, stb, rr, bz} = '0;
		repeat (60) begin
			@(negedge CORE_CLK_IN);
			g += (FIBRE_GATE_OUT === 1'b1);
			cap += (HIT_CAPTURE_CLOCK_OUT === 1'b1);
			rr += (REARM_OUT === 1'b1);
			bz += (BUSY_OUT === 1'b1);
			if (CLASSIFIER_CLOCK_OUT === 1'b1) s = 0;
			else if (stb == 0) s++;
			stb += (RESULT_STROBE_OUT === 1'b1);
		end
		tick(1);
	endtask : fire
	task automatic ev(input logic [7:0] sd, input logic [7:0] gw, input int es, input int eg);
		wr(`TRG_OFS_SDELAY, sd);
		wr(`TRG_OFS_GATEW, gw);
		fire(1);
		chk({cap[15:0], stb[15:0]}, 32'h0001_0001);
		chk(s, es);
		chk(g, eg);
		chk({CARD1_LEFT_POS_OUT, CARD2_LEFT_POS_OUT, CARD4_LEFT_POS_OUT}, {5'h3, 5'h3, 5'h9});
		chk({CARD1_RIGHT_POS_OUT, CARD2_RIGHT_POS_OUT, CARD3_RIGHT_POS_OUT, CARD4_RIGHT_POS_OUT, LEFT_NO_HIT_OUT,
			LEFT_TOO_MANY_OUT, LEFT_FIRST_VALID_OUT, LEFT_SECOND_VALID_OUT, RIGHT_NO_HIT_OUT, RIGHT_TOO_MANY_OUT,
			RIGHT_FIRST_VALID_OUT, RIGHT_SECOND_VALID_OUT}, 28'h38);
	endtask : ev
	initial begin
		tick(6);
		SYS_RST_IN <= 0;
		tick(1);
		chk({BUSY_OUT, READY_OUT, SEQUENCER_ENABLE_OUT, INPUT_REG_ENABLE_N_OUT, LEFT_TABLE_WRITE_N_OUT}, 5'h5);
		for (int m = 0; m < 5; m++) begin
			wr(`TRG_OFS_CTRL, m);
			chk({INPUT_REG_ENABLE_N_OUT, TABLE_ENABLE_N_OUT, CLASSIFIER_DRIVER_ENABLE_N_OUT, LEFT_TABLE_WRITE_N_OUT,
				RIGHT_TABLE_WRITE_N_OUT}, {men[m], 2'h3});
		end
		rdr(`TRG_OFS_CDELAY);
		chk(rd, 32'h1);
		rdr(8'h38);
		chk(rs, `TRG_RESP_SLVERR);
		wr(`TRG_OFS_STATUS, 32'h1);
		chk(rs, `TRG_RESP_SLVERR);
		// two-hit entry of the left table, then the empty right entry
		wr(`TRG_OFS_TEST_LEFT, 32'h104);
		wr(`TRG_OFS_TBL_DATA, {2{16'h3123}});
		wr(`TRG_OFS_TBL_CMD, 32'h1);
		wr(`TRG_OFS_TBL_DATA, {2{16'h0400}});
		wr(`TRG_OFS_TBL_CMD, 32'h2);
		wr(`TRG_OFS_CTRL, 32'h3);
		tick(2);
		rdr(`TRG_OFS_TBL_READ);
		chk(rd, 32'h04003123);
		wr(`TRG_OFS_CTRL, 32'h1);
		tick(4);
		chk({CARD1_LEFT_POS_OUT, CARD4_LEFT_POS_OUT, CARD2_RIGHT_POS_OUT}, 15'h0D20);
		wr(`TRG_OFS_CTRL, 32'h2);
		wr(`TRG_OFS_TEST_OUT, 32'h125);
		tick(2);
		chk({CARD1_LEFT_POS_OUT, CARD4_LEFT_POS_OUT}, 10'h0A9);
		wr(`TRG_OFS_CTRL, 32'h0);
		wr(`TRG_OFS_FDELAY, 8'h37);
		ev(8'h0A, 8'h37, 2, 2);
		ev(8'hFF, 8'h00, 14, 1);
		ev(8'h1E, 8'hFF, 3, 7);
		VETO_IN <= 1;
		tick(3);
		fire(0);
		chk(bz, 0);
		VETO_IN <= 0;
		wr(`TRG_OFS_CTRL, 32'h10);
		fire(0);
		chk({stb[15:0], READY_OUT}, {16'h1, 1'b1});
		fire(0);
		chk(bz, 0);
		wr(`TRG_OFS_CTRL, 32'h50);
		wr(`TRG_OFS_CTRL, 32'h10);
		chk(READY_OUT, 0);
		fire(0);
		chk(stb, 1);
		wr(`TRG_OFS_CTRL, 32'h40);
		wr(`TRG_OFS_CTRL, 32'h20);
		wr(`TRG_OFS_SEQTEST, 32'h3);
		chk({SEQUENCER_ENABLE_OUT, TEST_START_OUT, TEST_CLASSIFIER_CLOCK_OUT}, 3'h3);
		wr(`TRG_OFS_SEQTEST, 32'h0);
		wr(`TRG_OFS_CTRL, 32'h0);
		for (int a = 4; a <= 20; a += 4) wr(a, a == 16 ? 32'h1F : 32'hFF);
		fire(0);
		chk({rr[15:0], stb[15:0]}, 32'h0001_0000);
		conclude();
	end
endmodule : trg_top_tb_top
